//--- iefb_flag_bank.sv
`timescale 1ns/10ps
`default_nettype none
module iefb_flag_bank #(
    parameter int W = 1
) (
    iefb_flag_if.bank fi
);
    // Sticky flags; hardware set beats a software clear
    always_ff @(posedge fi.clk or negedge fi.rst_n)
    begin
        if (!fi.rst_n)
        begin
            fi.flags <= '0;
        end
        else
        begin
            fi.flags <= fi.set | (fi.wr ? fi.wdata : fi.flags);
        end
    end

    genvar i;
    generate
        for (i = 0; i < W; i++)
        begin : g_chk
            set_wins_a: assert property (@(posedge fi.clk) disable iff (!fi.rst_n)
                fi.set[i] |=> fi.flags[i])
                else $error("flag lost its set event");
            flag_hold_a: assert property (@(posedge fi.clk) disable iff (!fi.rst_n)
                fi.flags[i] && !(fi.wr && !fi.wdata[i]) |=> fi.flags[i])
                else $error("flag dropped without a clear");
        end
    endgenerate
endmodule : iefb_flag_bank
`default_nettype wire

//--- iefb_flag_if.sv
`timescale 1ns/10ps
`default_nettype none
interface iefb_flag_if #(parameter int W = 1) (
    input wire logic clk,
    input wire logic rst_n
);
    logic [W-1:0] set;
    logic wr;
    logic [W-1:0] wdata;
    logic [W-1:0] flags;
    modport bank (input clk, input rst_n, input set, input wr, input wdata, output flags);
    modport owner (output set, output wr, output wdata, input flags);
endinterface : iefb_flag_if
`default_nettype wire

//--- iefb_periph_model.sv
`timescale 1ns/10ps
`default_nettype none
module iefb_periph_model (
    // Clock
    input wire logic pclk,
    // Event strobes and status levels
    output logic [7:0] ev,
    output logic i2c_master,
    output logic rx_full,
    output logic tx_empty,
    // Pins
    output logic ext_pin,
    output logic [3:0] nibble
);
    initial
    begin
        ev = 8'h00;
        i2c_master = 1'b0;
        rx_full = 1'b0;
        tx_empty = 1'b0;
        ext_pin = 1'b0;
        nibble = 4'h0;
    end
    // One-cycle event strobe, entered just after a rising edge
    task pulse(input logic [7:0] m);
        ev <= m;
        @(posedge pclk);
        ev <= 8'h00;
    endtask : pulse
    task levels(input logic m, input logic rx, input logic tx, input logic ep,
                input logic [3:0] nb);
        i2c_master <= m;
        rx_full <= rx;
        tx_empty <= tx;
        ext_pin <= ep;
        nibble <= nb;
    endtask : levels
endmodule : iefb_periph_model
`default_nettype wire

//--- iefb_pkg.sv
`default_nettype none
package iefb_pkg;
    // Bus geometry
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int REG_W = 8;
    // Register indices; byte address is four times the index
    localparam logic [8:0] CORE_IDX0 = 9'h00b;
    localparam logic [8:0] CORE_IDX1 = 9'h08b;
    localparam logic [8:0] CORE_IDX2 = 9'h10b;
    localparam logic [8:0] CORE_IDX3 = 9'h18b;
    localparam logic [8:0] PFLAG_IDX = 9'h00c;
    localparam logic [8:0] PEN_IDX = 9'h08c;
    localparam logic [8:0] PIMG_IDX = 9'h0e0;
    localparam logic [ADDR_W-1:0] CORE_ADDR0 = {1'b0, CORE_IDX0, 2'b00};
    localparam logic [ADDR_W-1:0] CORE_ADDR1 = {1'b0, CORE_IDX1, 2'b00};
    localparam logic [ADDR_W-1:0] CORE_ADDR2 = {1'b0, CORE_IDX2, 2'b00};
    localparam logic [ADDR_W-1:0] CORE_ADDR3 = {1'b0, CORE_IDX3, 2'b00};
    localparam logic [ADDR_W-1:0] PFLAG_ADDR = {1'b0, PFLAG_IDX, 2'b00};
    localparam logic [ADDR_W-1:0] PEN_ADDR = {1'b0, PEN_IDX, 2'b00};
    localparam logic [ADDR_W-1:0] PIMG_ADDR = {1'b0, PIMG_IDX, 2'b00};
    // Core control fields
    localparam int GLOB_EN_BIT = 7;
    localparam int GROUP_EN_BIT = 6;
    localparam int T0IE_BIT = 5;
    localparam int EXTIE_BIT = 4;
    localparam int PCIE_BIT = 3;
    localparam int T0IF_BIT = 2;
    localparam int EXTIF_BIT = 1;
    localparam int PCIF_BIT = 0;
    localparam int CORE_FLAGS = 3;
    // Peripheral flag fields
    localparam int PAR_BIT = 7;
    localparam int ADC_BIT = 6;
    localparam int RX_BIT = 5;
    localparam int TX_BIT = 4;
    localparam int SYNC_BIT = 3;
    localparam int CCP_BIT = 2;
    localparam int T2_BIT = 1;
    localparam int T1_BIT = 0;
    localparam int PERIPH_STICKY = 6;
    // Port B image fields
    localparam int PB_NIB_LSB = 4;
    localparam int PB_NIB_W = 4;
    // Reset values
    localparam logic [4:0] CORE_EN_RST = 5'h00;
    localparam logic [REG_W-1:0] PEN_RST = 8'h00;
    localparam logic [PB_NIB_W-1:0] PB_LATCH_RST = 4'h0;
    localparam logic [DATA_W-1:0] PRDATA_RST = 32'h0000_0000;
endpackage : iefb_pkg
`default_nettype wire

//--- iefb_tb.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin bad_count++; \
    $display("ERROR %0t: got %h exp %h", $time, g, e); end end
module tb_top;
    import iefb_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [ADDR_W-1:0] paddr = '0;
    logic [DATA_W-1:0] pwdata = '0;
    logic [3:0] pstrb = 4'hf;
    logic [DATA_W-1:0] prdata;
    logic [DATA_W-1:0] rdata;
    logic pready;
    logic pslverr;
    logic rerr;
    logic core_irq;
    logic [7:0] ev;
    logic i2c_m, rxf, txe, ep;
    logic [3:0] nib;
    int bad_count = 0;
    int samples_checked = 0;
    always #2 pclk = ~pclk;
    iefb_periph_model src (.pclk(pclk), .ev(ev), .i2c_master(i2c_m), .rx_full(rxf),
        .tx_empty(txe), .ext_pin(ep), .nibble(nib));
    iefb_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .external_edge_pin(ep),
        .port_b_upper_nibble(nib), .timer0_overflow_evt(ev[0]),
        .parallel_port_access_evt(ev[7]), .conversion_done_evt(ev[6]),
        .serial_rx_full(rxf), .serial_tx_empty(txe), .sync_serial_xfer_evt(ev[5]),
        .sync_serial_seq_evt(ev[4]), .sync_serial_i2c_master(i2c_m),
        .capcomp_one_evt(ev[3]), .timer2_match_evt(ev[2]), .timer1_overflow_evt(ev[1]),
        .core_irq(core_irq));
    task apb(input logic w, input logic [ADDR_W-1:0] a, input logic [7:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h000000, d};
        @(posedge pclk);
        penable <= 1'b1;
        while (pready !== 1'b1) @(posedge pclk);
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task chk_rd(input logic [ADDR_W-1:0] a, input logic [7:0] e);
        apb(1'b0, a, 8'h00);
        `CHK(rdata, {24'h000000, e})
    endtask : chk_rd
    task chk_irq(input logic e);
        repeat (3) @(posedge pclk);
        @(negedge pclk);
        `CHK(core_irq, e)
        @(posedge pclk);
    endtask : chk_irq
    task t_regs;
        logic [ADDR_W-1:0] m[4];
        m = '{CORE_ADDR0, CORE_ADDR1, CORE_ADDR2, CORE_ADDR3};
        chk_rd(PEN_ADDR, 8'h00);
        apb(1'b0, 12'h004, 8'h00);
        `CHK(rerr, 1'b1)
        apb(1'b1, PEN_ADDR, 8'h7f);
        chk_rd(PEN_ADDR, 8'h7f);
        pstrb <= 4'he;
        apb(1'b1, PEN_ADDR, 8'h55);
        pstrb <= 4'hf;
        chk_rd(PEN_ADDR, 8'h7f);
        for (int i = 0; i < 4; i++)
        begin
            apb(1'b1, m[i], 8'h08 << i);
            chk_rd(m[(i + 1) % 4], 8'h08 << i);
        end
        apb(1'b1, CORE_ADDR0, 8'h00);
    endtask : t_regs
    task t_flags;
        src.pulse(8'hef);
        chk_rd(PFLAG_ADDR, 8'hcf);
        chk_rd(CORE_ADDR1, 8'h04);
        apb(1'b1, PFLAG_ADDR, 8'h00);
        apb(1'b1, CORE_ADDR0, 8'h00);
        src.pulse(8'h10);
        chk_rd(PFLAG_ADDR, 8'h00);
        src.levels(1'b1, 1'b1, 1'b0, 1'b0, 4'h0);
        src.pulse(8'h10);
        chk_rd(PFLAG_ADDR, 8'h28);
        apb(1'b1, PFLAG_ADDR, 8'h10);
        chk_rd(PFLAG_ADDR, 8'h20);
        src.levels(1'b0, 1'b0, 1'b1, 1'b0, 4'h0);
        chk_rd(PFLAG_ADDR, 8'h10);
        src.levels(1'b0, 1'b0, 1'b0, 1'b0, 4'h0);
    endtask : t_flags
    task t_irq;
        src.pulse(8'h02);
        apb(1'b1, PEN_ADDR, 8'h01);
        apb(1'b1, CORE_ADDR0, 8'h80);
        chk_irq(1'b0);
        apb(1'b1, CORE_ADDR0, 8'hc0);
        chk_irq(1'b1);
        apb(1'b1, CORE_ADDR0, 8'h40);
        chk_irq(1'b0);
        apb(1'b1, PFLAG_ADDR, 8'h00);
        src.pulse(8'h01);
        apb(1'b1, CORE_ADDR0, 8'ha4);
        chk_irq(1'b1);
        apb(1'b1, CORE_ADDR0, 8'h24);
        chk_irq(1'b0);
        fork
            apb(1'b1, CORE_ADDR0, 8'h00);
            begin
                @(posedge pclk);
                src.pulse(8'h01);
            end
        join
        chk_rd(CORE_ADDR0, 8'h04);
        apb(1'b1, CORE_ADDR0, 8'h00);
    endtask : t_irq
    task t_pins;
        src.levels(1'b0, 1'b0, 1'b0, 1'b1, 4'ha);
        repeat (8) @(posedge pclk);
        src.levels(1'b0, 1'b0, 1'b0, 1'b0, 4'ha);
        repeat (8) @(posedge pclk);
        chk_rd(CORE_ADDR0, 8'h03);
        apb(1'b1, CORE_ADDR0, 8'h00);
        chk_rd(CORE_ADDR0, 8'h01);
        chk_rd(PIMG_ADDR, 8'ha0);
        apb(1'b1, CORE_ADDR0, 8'h00);
        chk_rd(CORE_ADDR0, 8'h00);
    endtask : t_pins
    task tally_and_finish;
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : tally_and_finish
    initial
    begin
        repeat (5000) @(posedge pclk);
        bad_count++;
        tally_and_finish();
    end
    initial
    begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_regs();
        t_flags();
        t_irq();
        t_pins();
        tally_and_finish();
    end
endmodule : tb_top
`default_nettype wire

//--- iefb_top.sv
`timescale 1ns/10ps
`default_nettype none
// Operation
// - Flags set regardless of any enable
// - Global enable passes or blocks all requests
// - Group enable gates every peripheral request
// - Core control holds five enables and three flags
// - Core control readable, writable at four mirrors
// - External pin flag sticky until cleared
// - Upper port nibble mismatch sets change flag
// - Mismatch keeps setting; port read ends it
// - Peripheral enable register, eight source enables
// - Parallel port access flag in the peripheral flag register
// - Conversion done flag sticky until cleared
// - Receive flag read-only, mirrors buffer full
// - Transmit flag read-only, mirrors buffer empty
// - Sync serial flag on completed transfer
// - Master mode sequences also set that flag
// - Capture, timer2, timer1 flags sticky
module iefb_top
    import iefb_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [DATA_W-1:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    // Pins
    input wire logic external_edge_pin,
    input wire logic [PB_NIB_W-1:0] port_b_upper_nibble,
    // Peripheral events, same clock
    input wire logic timer0_overflow_evt,
    input wire logic parallel_port_access_evt,
    input wire logic conversion_done_evt,
    input wire logic serial_rx_full,
    input wire logic serial_tx_empty,
    input wire logic sync_serial_xfer_evt,
    input wire logic sync_serial_seq_evt,
    input wire logic sync_serial_i2c_master,
    input wire logic capcomp_one_evt,
    input wire logic timer2_match_evt,
    input wire logic timer1_overflow_evt,
    // Request to core
    output logic core_irq
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    logic apb_setup;
    logic apb_access;
    logic hit_core;
    logic hit_pflag;
    logic hit_pen;
    logic hit_pimg;
    logic hit_any;
    logic wr_ok;
    logic rd_pimg;
    logic [REG_W-1:0] core_view;
    logic [REG_W-1:0] pflag_view;
    logic [REG_W-1:0] pb_view;
    logic [REG_W-1:0] rd_val;
    logic [DATA_W-1:0] prdata_q;
    logic slverr_q;
    logic [7:3] core_en_q;
    logic [REG_W-1:0] pen_q;
    logic ext_s1_q;
    logic ext_s2_q;
    logic ext_s3_q;
    logic ext_f_q;
    logic ext_prev_q;
    logic ext_rise;
    logic [PB_NIB_W-1:0] pb_s1_q;
    logic [PB_NIB_W-1:0] pb_s2_q;
    logic [PB_NIB_W-1:0] pb_s3_q;
    logic [PB_NIB_W-1:0] pb_f_q;
    logic [PB_NIB_W-1:0] pb_latch_q;
    logic pb_mismatch;
    logic sync_set;
    logic core_any;
    logic periph_any;
    logic irq_d;
    logic irq_q;

    iefb_flag_if #(.W(CORE_FLAGS)) core_fi (.clk(pclk), .rst_n(presetn));
    iefb_flag_if #(.W(PERIPH_STICKY)) per_fi (.clk(pclk), .rst_n(presetn));

    iefb_flag_bank #(.W(CORE_FLAGS)) u_core_flags (.fi(core_fi));
    iefb_flag_bank #(.W(PERIPH_STICKY)) u_per_flags (.fi(per_fi));

    // Address decode
    assign apb_setup = psel & ~penable;
    assign apb_access = psel & penable;

    always_comb
    begin
        hit_core = (paddr == CORE_ADDR0) || (paddr == CORE_ADDR1)
            || (paddr == CORE_ADDR2) || (paddr == CORE_ADDR3);
        hit_pflag = (paddr == PFLAG_ADDR);
        hit_pen = (paddr == PEN_ADDR);
        hit_pimg = (paddr == PIMG_ADDR);
        hit_any = hit_core | hit_pflag | hit_pen | hit_pimg;
    end

    assign wr_ok = apb_access & pwrite & pstrb[0] & hit_any;
    assign rd_pimg = apb_access & ~pwrite & hit_pimg;

    // Register images
    always_comb
    begin
        core_view = {core_en_q, core_fi.flags};
        pflag_view = {per_fi.flags[5:4], serial_rx_full, serial_tx_empty,
            per_fi.flags[3:0]};
        pb_view = '0;
        pb_view[PB_NIB_LSB +: PB_NIB_W] = pb_f_q;
        pb_view[0] = ext_f_q;
        rd_val = '0;
        if (hit_core)
        begin
            rd_val = core_view;
        end
        else if (hit_pflag)
        begin
            rd_val = pflag_view;
        end
        else if (hit_pen)
        begin
            rd_val = pen_q;
        end
        else if (hit_pimg)
        begin
            rd_val = pb_view;
        end
    end

    // Read data and error captured in the setup cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata_q <= PRDATA_RST;
            slverr_q <= 1'b0;
        end
        else if (apb_setup)
        begin
            prdata_q <= {{(DATA_W-REG_W){1'b0}}, rd_val};
            slverr_q <= ~hit_any;
        end
    end

    assign prdata = prdata_q;
    assign pready = apb_access;
    assign pslverr = apb_access & slverr_q;

    // Core enables
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            core_en_q <= CORE_EN_RST;
        end
        else if (wr_ok && hit_core)
        begin
            core_en_q <= pwdata[7:3];
        end
    end

    // Peripheral enables
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pen_q <= PEN_RST;
        end
        else if (wr_ok && hit_pen)
        begin
            pen_q <= pwdata[REG_W-1:0];
        end
    end

    // External pin synchroniser and filter
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ext_s1_q <= 1'b0;
            ext_s2_q <= 1'b0;
            ext_s3_q <= 1'b0;
            ext_f_q <= 1'b0;
            ext_prev_q <= 1'b0;
        end
        else
        begin
            ext_s1_q <= external_edge_pin;
            ext_s2_q <= ext_s1_q;
            ext_s3_q <= ext_s2_q;
            if (ext_s2_q == ext_s3_q)
            begin
                ext_f_q <= ext_s3_q;
            end
            ext_prev_q <= ext_f_q;
        end
    end

    assign ext_rise = ext_f_q & ~ext_prev_q;

    // Port nibble synchroniser, filter and last-read latch
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pb_s1_q <= '0;
            pb_s2_q <= '0;
            pb_s3_q <= '0;
            pb_f_q <= '0;
        end
        else
        begin
            pb_s1_q <= port_b_upper_nibble;
            pb_s2_q <= pb_s1_q;
            pb_s3_q <= pb_s2_q;
            for (int i = 0; i < PB_NIB_W; i++)
            begin
                if (pb_s2_q[i] == pb_s3_q[i])
                begin
                    pb_f_q[i] <= pb_s3_q[i];
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pb_latch_q <= PB_LATCH_RST;
        end
        else if (rd_pimg)
        begin
            pb_latch_q <= pb_f_q;
        end
    end

    assign pb_mismatch = (pb_f_q != pb_latch_q);

    // Flag set and clear paths
    assign sync_set = sync_serial_xfer_evt
        | (sync_serial_seq_evt & sync_serial_i2c_master);

    always_comb
    begin
        core_fi.set = {timer0_overflow_evt, ext_rise, pb_mismatch};
        core_fi.wr = wr_ok & hit_core;
        core_fi.wdata = pwdata[CORE_FLAGS-1:0];
        per_fi.set = {parallel_port_access_evt, conversion_done_evt, sync_set,
            capcomp_one_evt, timer2_match_evt, timer1_overflow_evt};
        per_fi.wr = wr_ok & hit_pflag;
        per_fi.wdata = {pwdata[PAR_BIT], pwdata[ADC_BIT], pwdata[SYNC_BIT:T1_BIT]};
    end

    // Request to core
    always_comb
    begin
        core_any = |(core_en_q[T0IE_BIT:PCIE_BIT] & core_fi.flags);
        periph_any = |(pen_q & pflag_view);
        irq_d = core_en_q[GLOB_EN_BIT]
            & (core_any | (core_en_q[GROUP_EN_BIT] & periph_any));
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            irq_q <= 1'b0;
        end
        else
        begin
            irq_q <= irq_d;
        end
    end

    assign core_irq = irq_q;

    // Checks
    glob_block_a: assert property (!core_en_q[GLOB_EN_BIT] |=> !core_irq)
        else $error("request passed with global enable clear");

    core_pair_a: assert property (core_en_q[GLOB_EN_BIT] && core_en_q[T0IE_BIT]
        && core_fi.flags[T0IF_BIT] |=> core_irq)
        else $error("enabled pending source gave no request");

    group_block_a: assert property (!core_en_q[GROUP_EN_BIT] && !core_any |=> !core_irq)
        else $error("peripheral request passed with group enable clear");

    flag_indep_a: assert property (timer0_overflow_evt |=> core_fi.flags[T0IF_BIT])
        else $error("event did not set its flag");

    pb_mismatch_a: assert property (pb_mismatch |=> core_fi.flags[PCIF_BIT])
        else $error("port mismatch did not hold change flag");

    rx_view_a: assert property (apb_setup && hit_pflag
        |=> prdata[RX_BIT] == $past(serial_rx_full))
        else $error("receive flag image wrong");

    tx_view_a: assert property (apb_setup && hit_pflag
        |=> prdata[TX_BIT] == $past(serial_tx_empty))
        else $error("transmit flag image wrong");

    sync_master_a: assert property (sync_serial_seq_evt && sync_serial_i2c_master
        |=> per_fi.flags[SYNC_BIT])
        else $error("master sequence did not set serial flag");

    pen_write_a: assert property (wr_ok && hit_pen
        |=> pen_q == $past(pwdata[REG_W-1:0]))
        else $error("peripheral enable write lost");

    core_mirror_a: assert property (wr_ok && (paddr == CORE_ADDR3)
        |=> core_en_q == $past(pwdata[7:3]))
        else $error("mirror write of core control lost");

    apb_answer_a: assert property (apb_setup ##1 apb_access
        |-> pready && (pslverr == !hit_any))
        else $error("access answer or error flag wrong");

    strb_block_a: assert property (apb_access && pwrite && !pstrb[0] && hit_pen
        |=> $stable(pen_q))
        else $error("masked write changed enables");

    ext_flag_a: assert property (ext_rise |=> core_fi.flags[EXTIF_BIT])
        else $error("pin edge did not set its flag");
endmodule : iefb_top
`default_nettype wire
